//--- core/rsa_pkg.sv
// Function
// RULE1 - device answers only as a target: start, identification address, then data bytes
// RULE2 - consecutive locations follow each other in one transfer until the stop
// RULE3 - supply below power_fail_threshold blocks every read and write of the clock registers
// RULE4 - after supply returns, access stays refused until the reset output is high
// RULE5 - memory space is three separately addressed blocks
// RULE6 - block-select bits in the slave address byte route the access
// RULE7 - timekeeping, watchdog, trickle, flag and control registers sit in block 0
// RULE8 - block 0 pointer wraps from location 0x0c back to 0x00
// RULE9 - start, or block 0 pointer reaching 0x00, copies live time into the shadow set
// RULE10 - time reads return the shadow copy while live counters keep running
// RULE11 - nonvolatile storage is two 256-byte regions in blocks 1 and 2
// RULE12 - nonvolatile read wraps 0xff to 0x00 of the same block
// RULE13 - nonvolatile write wraps inside the current 8-byte page
// RULE14 - master should finish time writes before hundredths reaches 99
// RULE15 - time and calendar contents are binary-coded decimal on read and write
// RULE16 - pointer advances by one per data byte, subject to block wrap
// RULE17 - while blocked, the slave address is not acknowledged and nothing changes
package rsa_pkg;
  localparam logic [1:0] BLK_TIME      = 2'h0;
  localparam logic [1:0] BLK_EE_LO     = 2'h1;
  localparam logic [1:0] BLK_EE_HI     = 2'h2;
  localparam logic [7:0] PTR_FIRST     = 8'h00;
  localparam logic [7:0] SHADOW_LAST   = 8'h07;
  localparam logic [7:0] CTRL_FIRST    = 8'h08;
  localparam logic [7:0] TIME_LAST     = 8'h0c;
  localparam logic [7:0] EE_LAST       = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned CTRL_N       = 5;
  localparam int unsigned EE_BLOCK_SZ  = 256;
  localparam int unsigned EE_DEPTH     = 2 * EE_BLOCK_SZ;
  localparam int unsigned PAGE_BITS_DF = 3;

  // byte order: hundredths sits in the low byte (location 0x00)
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] hundredths;
  } rsa_time_s;

  typedef logic [7:0][7:0]        rsa_tbytes_t;
  typedef logic [CTRL_N-1:0][7:0] rsa_ctrl_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] addr;
    logic [7:0] data;
  } rsa_wr_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WORD, ST_WACK, ST_WDATA, ST_DACK, ST_RDATA, ST_RACK
  } rsa_state_e;

  typedef struct packed {
    rsa_state_e st;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] blk;
    logic       rw;
    logic [7:0] ptr;
    rsa_time_s  shadow;
    logic       sda_o;
    logic       sda_oe;
    logic       ack_seen;
    rsa_wr_s    wr;
    logic       ee_we;
    logic [8:0] ee_addr;
    logic [7:0] ee_data;
  } rsa_st_s;
endpackage

//--- core/rsa_serial_access.sv
module rsa_serial_access #(
  parameter logic [4:0]  DEV_ID    = 5'h0b,  // arbitrary identification value
  parameter int unsigned PAGE_BITS = rsa_pkg::PAGE_BITS_DF
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // serial bus, open drain data
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  // supply supervision
  input  wire logic               below_power_fail_threshold,
  input  wire logic               rst_out_n,
  // timekeeping side
  input  wire rsa_pkg::rsa_time_s live_time,
  input  wire rsa_pkg::rsa_ctrl_t ctrl_regs,
  output rsa_pkg::rsa_wr_s        reg_wr
);
  import rsa_pkg::*;

  if (PAGE_BITS < 1 || PAGE_BITS > 7) begin : g_chk
    $error("rsa_serial_access: PAGE_BITS must be 1..7");
  end

  rsa_st_s    q;
  rsa_st_s    d;
  logic [7:0] ee_mem [EE_DEPTH];
  logic [7:0] ee_rd;
  logic [7:0] rd;
  logic [7:0] nxt;
  logic       access_ok;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       adv;

  function automatic logic [8:0] ee_idx(input logic [1:0] blk, input logic [7:0] p);
    ee_idx = {blk == BLK_EE_HI, p};  // [RULE11]
  endfunction

  function automatic logic [7:0] next_ptr(input logic [1:0] blk, input logic wr,
                                          input logic [7:0] p);
    logic [7:0] inc;
    inc = p + 8'h01;
    if (blk == BLK_TIME) begin
      next_ptr = (p >= TIME_LAST) ? PTR_FIRST : inc;  // [RULE8]
    end else if (wr) begin
      next_ptr = {p[7:PAGE_BITS], inc[PAGE_BITS-1:0]};  // [RULE13]
    end else begin
      next_ptr = inc;  // 0xff rolls to 0x00, block unchanged [RULE12]
    end
  endfunction

  function automatic logic [7:0] rd_byte(input logic [1:0] blk, input logic [7:0] p,
                                         input rsa_time_s t, input rsa_ctrl_t c,
                                         input logic [7:0] ee);
    logic [7:0] off;
    rsa_tbytes_t tb;
    off = p - CTRL_FIRST;
    tb  = rsa_tbytes_t'(t);
    if (blk != BLK_TIME) begin
      rd_byte = ee;
    end else if (p <= SHADOW_LAST) begin
      rd_byte = tb[p[2:0]];  // [RULE10]
    end else if (p <= TIME_LAST) begin
      rd_byte = c[off[2:0]];  // [RULE7]
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // a low supply or a held reset output closes the port entirely [RULE3] [RULE4]
  assign access_ok = !below_power_fail_threshold && rst_out_n;
  assign rise      = scl_i && !q.scl_q;
  assign fall      = !scl_i && q.scl_q;
  assign start_c   = scl_i && q.scl_q && q.sda_q && !sda_i;
  assign stop_c    = scl_i && q.scl_q && !q.sda_q && sda_i;
  assign ee_rd     = ee_mem[ee_idx(q.blk, q.ptr)];
  assign rd        = rd_byte(q.blk, q.ptr, q.shadow, ctrl_regs, ee_rd);
  assign nxt       = next_ptr(q.blk, !q.rw, q.ptr);

  always_comb begin
    d        = q;
    d.scl_q  = scl_i;
    d.sda_q  = sda_i;
    d.wr.vld = 1'b0;
    d.ee_we  = 1'b0;
    adv      = 1'b0;
    if (!access_ok) begin
      d.st     = ST_IDLE;  // no acknowledge, state forced back to ST_IDLE [RULE17]
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.st     = ST_ADDR;  // [RULE1]
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
      d.shadow = live_time;  // [RULE9]
    end else if (stop_c) begin
      d.st     = ST_IDLE;  // [RULE2]
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        ST_ADDR, ST_WORD, ST_WDATA: begin
          if (rise) begin
            d.sh  = {q.sh[6:0], sda_i};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == BITS_PER_BYTE) begin
            d.cnt = 4'h0;
            if (q.st == ST_ADDR) begin
              // block 3 does not exist, so it is left unanswered [RULE5]
              if (q.sh[7:3] == DEV_ID && q.sh[2:1] != 2'h3) begin
                d.blk    = q.sh[2:1];  // [RULE6]
                d.rw     = q.sh[0];
                d.sda_oe = 1'b1;
                d.st     = ST_AACK;
              end else begin
                d.st = ST_IDLE;
              end
            end else if (q.st == ST_WORD) begin
              d.ptr    = q.sh;
              d.sda_oe = 1'b1;
              d.st     = ST_WACK;
            end else begin
              if (q.blk == BLK_TIME) begin
                // data passes unchanged; the counters keep it in BCD [RULE15]
                d.wr = '{vld: 1'b1, addr: q.ptr, data: q.sh};
              end else begin
                d.ee_we   = 1'b1;
                d.ee_addr = ee_idx(q.blk, q.ptr);
                d.ee_data = q.sh;
              end
              adv      = 1'b1;
              d.sda_oe = 1'b1;
              d.st     = ST_DACK;
            end
          end
        end
        ST_AACK, ST_WACK, ST_DACK: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
            if (q.st == ST_AACK && q.rw) begin
              d.sh     = rd;
              d.sda_oe = !rd[7];
              d.st     = ST_RDATA;
            end else if (q.st == ST_AACK) begin
              d.st = ST_WORD;
            end else begin
              d.st = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (fall) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == BITS_PER_BYTE - 4'h1) begin
              d.sda_oe = 1'b0;
              d.st     = ST_RACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            d.ack_seen = !sda_i;
            adv        = 1'b1;  // pointer moves even on the final nack [RULE16]
          end else if (fall) begin
            d.cnt = 4'h0;
            if (q.ack_seen) begin
              d.sh     = rd;  // [RULE2]
              d.sda_oe = !rd[7];
              d.st     = ST_RDATA;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end
    if (adv) begin
      d.ptr = nxt;  // [RULE16]
      if (q.blk == BLK_TIME && nxt == PTR_FIRST) begin
        d.shadow = live_time;  // [RULE9]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q       <= '0;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // eeprom cells have no reset; programming time is not modelled
  always_ff @(posedge clk) begin
    if (q.ee_we) begin
      ee_mem[q.ee_addr] <= q.ee_data;  // [RULE11]
    end
  end

  assign sda_o  = q.sda_o;
  assign sda_oe = q.sda_oe;
  assign reg_wr = q.wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start;
    access_ok && start_c;
  endsequence
  sequence s_stop;
    access_ok && !start_c && stop_c;
  endsequence
  sequence s_addr_acked;
    q.st == ST_AACK && $past(q.st) == ST_ADDR;
  endsequence

  AST_ADDR_GATED: assert property (s_addr_acked |-> $past(access_ok) && q.sda_oe) // [RULE17]
    else $error("address acknowledged while access blocked");
  AST_BLOCKED_IDLE: assert property (!access_ok |=> q.st == ST_IDLE && !q.sda_oe) // [RULE3]
    else $error("bus still active while access blocked");
  AST_NO_WR_BLOCKED: assert property (!access_ok |=> !q.wr.vld && !q.ee_we) // [RULE4]
    else $error("write issued while access blocked");
  AST_SNAP_START: assert property (s_start |=> q.shadow == $past(live_time)) // [RULE9]
    else $error("shadow not loaded on start");
  AST_TIME_WRAP: assert property (adv && q.blk == BLK_TIME && q.ptr == TIME_LAST // [RULE8]
    |=> q.ptr == PTR_FIRST && q.shadow == $past(live_time))
    else $error("block 0 pointer did not wrap with snapshot");
  AST_EE_RD_WRAP: assert property (adv && q.blk != BLK_TIME && q.rw && q.ptr == EE_LAST // [RULE12]
    |=> q.ptr == PTR_FIRST && q.blk == $past(q.blk))
    else $error("nonvolatile read pointer did not wrap in block");
  AST_PAGE_WRAP: assert property (adv && q.blk != BLK_TIME && !q.rw // [RULE13]
    |=> q.ptr[7:PAGE_BITS] == $past(q.ptr[7:PAGE_BITS]) && q.ptr != $past(q.ptr))
    else $error("write pointer left its page");
  AST_INC: assert property (adv && q.rw && q.ptr != EE_LAST && q.ptr < TIME_LAST // [RULE16]
    |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("pointer did not advance by one");
  AST_STOP: assert property (s_stop |=> q.st == ST_IDLE ##1 !q.wr.vld) // [RULE2]
    else $error("stop did not end the transfer");
  AST_BLK_SEL: assert property (s_addr_acked |-> q.blk == $past(q.sh[2:1]) // [RULE6]
    && q.blk != 2'h3)
    else $error("block not taken from address byte");
endmodule

//--- tb/rsa_i2c_master_model.sv
module rsa_i2c_master_model (
  // clock
  input  wire logic clk,
  // bus wires, sda_m high means released
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // every change lands 1 ns after an edge so no sample sees a moving wire
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_m = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_m = 1'b0;
    hc(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_m = 1'b1;
    hc(4);
  endtask
  task automatic io(input logic b, output logic r);
    sda_m = b;
    hc(4);
    scl = 1'b1;
    hc(2);
    r = sda;
    hc(2);
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) io(d[i], r);
    io(1'b1, r);
    ack = ~r;
  endtask
  // a low acknowledge asks for the next location in sequence
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) io(1'b1, d[i]);
    io(last, r);
  endtask
endmodule

//--- tb/rtc_serial_access_map_tb_top.sv
module rtc_serial_access_map_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rsa_pkg::*;
  localparam logic [4:0] ID = 5'h0b;  // arbitrary identification value
  logic       clk, reset, scl, m_sda, sda, sda_o, sda_oe, below, rst_out_n;
  rsa_time_s  live_time;
  rsa_ctrl_t  ctrl_regs;
  rsa_wr_s    reg_wr;
  logic [15:0] wq[$];
  int         miscompares, num_checks;
  assign sda = (sda_oe ? sda_o : 1'b1) & m_sda;
  rsa_serial_access #(.DEV_ID(ID)) rsa_serial_access_inst (
    .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .below_power_fail_threshold(below), .rst_out_n(rst_out_n), .live_time(live_time),
    .ctrl_regs(ctrl_regs), .reg_wr(reg_wr));
  rsa_i2c_master_model m (.clk(clk), .scl(scl), .sda_m(m_sda), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (reg_wr.vld === 1'b1) wq.push_back({reg_wr.addr, reg_wr.data});
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic adr(input logic [1:0] b, input logic rw, input logic e);
    logic a;
    m.wbyte({ID, b, rw}, a);
    chk("address ack", 16'(a), 16'(e));
  endtask
  task automatic wr(input logic [1:0] b, input logic [7:0] w, input logic [7:0] d);
    logic a;
    m.start();
    adr(b, 1'b0, 1'b1);
    m.wbyte(w, a);
    m.wbyte(d, a);
    m.stop();
  endtask
  task automatic seek(input logic [1:0] b, input logic [7:0] w);
    logic a;
    m.start();
    adr(b, 1'b0, 1'b1);
    m.wbyte(w, a);
    m.start();
    adr(b, 1'b1, 1'b1);
  endtask
  task automatic rd(input logic l, input logic [7:0] e);
    logic [7:0] d;
    m.rbyte(d, l);
    chk("read byte", 16'(d), 16'(e));
  endtask
  task automatic t_time();
    // hundredths kept far from 99 so no rollover hits a burst
    live_time = 64'h2412150309453012;
    seek(2'h0, 8'h00);
    live_time = 64'h2501010101010150;
    rd(1'b0, 8'h12);
    rd(1'b1, 8'h30);
    m.stop();
    seek(2'h0, 8'h0b);
    live_time.hundredths = 8'h47;
    rd(1'b0, 8'hc3);
    rd(1'b0, 8'hc4);
    rd(1'b1, 8'h47);
    m.stop();
    // locations past the last control byte read as zero
    seek(2'h0, 8'h20);
    rd(1'b1, 8'h00);
    m.stop();
    $display("time read test done");
  endtask
  task automatic t_wr0();
    logic a;
    wq.delete();
    m.start();
    adr(2'h0, 1'b0, 1'b1);
    m.wbyte(8'h0b, a);
    m.wbyte(8'h5a, a);
    m.wbyte(8'h33, a);
    m.wbyte(8'h77, a);
    m.stop();
    chk("write count", 16'(wq.size()), 16'h0003);
    chk("write 1", wq[0], 16'h0b5a);
    chk("write 2", wq[1], 16'h0c33);
    chk("write 3", wq[2], 16'h0077);
    $display("block 0 write test done");
  endtask
  task automatic t_ee();
    logic a;
    wq.delete();
    m.start();
    adr(2'h1, 1'b0, 1'b1);
    m.wbyte(8'h0e, a);
    m.wbyte(8'ha1, a);
    m.wbyte(8'ha2, a);
    m.wbyte(8'ha3, a);
    m.stop();
    seek(2'h1, 8'h08);
    rd(1'b1, 8'ha3);
    m.stop();
    wr(2'h2, 8'hff, 8'hb1);
    wr(2'h2, 8'h00, 8'hb2);
    wr(2'h1, 8'h00, 8'hc1);
    seek(2'h2, 8'hff);
    rd(1'b0, 8'hb1);
    rd(1'b1, 8'hb2);
    m.stop();
    chk("no block 0 write", 16'(wq.size()), 16'h0000);
    $display("nonvolatile test done");
  endtask
  task automatic t_block();
    logic a;
    wq.delete();
    below = 1'b1;
    m.start();
    adr(2'h0, 1'b0, 1'b0);
    m.wbyte(8'h01, a);
    m.wbyte(8'h99, a);
    m.stop();
    m.start();
    adr(2'h1, 1'b0, 1'b0);
    m.wbyte(8'h00, a);
    m.wbyte(8'h55, a);
    m.stop();
    below = 1'b0;
    rst_out_n = 1'b0;
    m.start();
    adr(2'h0, 1'b0, 1'b0);
    m.stop();
    rst_out_n = 1'b1;
    m.start();
    m.wbyte({ID ^ 5'h01, 2'h0, 1'b0}, a);
    chk("foreign id ack", 16'(a), 16'h0000);
    m.start();
    adr(2'h3, 1'b0, 1'b0);
    m.start();
    adr(2'h0, 1'b0, 1'b1);
    m.stop();
    // the blocked write to block 1 must have left the earlier byte in place
    seek(2'h1, 8'h00);
    rd(1'b1, 8'hc1);
    m.stop();
    chk("blocked write", 16'(wq.size()), 16'h0000);
    $display("access block test done");
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    below = 1'b0;
    rst_out_n = 1'b1;
    live_time = '0;
    ctrl_regs = {8'hc4, 8'hc3, 8'hc2, 8'hc1, 8'hc0};
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    m.hc(2);
    t_time();
    t_wr0();
    t_ee();
    t_block();
    print_verdict();
  end
endmodule
